//--- design/ecl_pkg.sv
// Constants, tables and state types of the configuration loader.
// Assumes a 10 MHz core clock and a byte-addressed two-wire EEPROM.
package ecl_pkg;

  // Six configuration bytes, three per serial port
  localparam int NUM_CFG = 6;

  // Application number that selects the configuration registers
  localparam logic [7:0] APP_NUM_CFG = 8'h00;

  // Register index of each configuration byte, in slot order
  localparam logic [7:0] CFG_IDX [NUM_CFG] =
    '{8'h04, 8'h05, 8'h06, 8'h19, 8'h1a, 8'h1b};

  // EEPROM location of each configuration byte, in slot order
  localparam logic [7:0] CFG_EE_LOC [NUM_CFG] =
    '{8'h08, 8'h09, 8'h0a, 8'h0e, 8'h0f, 8'h10};

  // Built-in defaults, kept when no EEPROM answers
  localparam logic [7:0] CFG_RST [NUM_CFG] =
    '{8'h01, 8'h85, 8'h24, 8'h01, 8'h84, 8'h24};

  // Presence-check word locations, low byte first
  localparam logic [7:0] EE_LOC_CHK_LO = 8'h00;
  localparam logic [7:0] EE_LOC_CHK_HI = 8'h01;

  // Load steps: two check bytes, then six configuration bytes
  localparam logic [2:0] STEP_CHK_LO   = 3'h0;
  localparam logic [2:0] STEP_CHK_HI   = 3'h1;
  localparam logic [2:0] STEP_CFG_BASE = 3'h2;
  localparam logic [2:0] STEP_LAST     = 3'h7;

  // Two-wire bus: device address and quarter-bit timing
  localparam logic [6:0] EE_DEV_ADDR     = 7'h50;
  localparam int         CLK_PERIOD_NS   = 100;
  localparam int         I2C_QUARTER_NS  = 2500;
  localparam int         I2C_QUARTER_CYC = I2C_QUARTER_NS / CLK_PERIOD_NS;
  localparam logic [4:0] Q_CNT_LAST      = 5'(I2C_QUARTER_CYC - 1);

  // Operations of one random read, executed in order
  localparam logic [2:0] OP_START  = 3'h0;
  localparam logic [2:0] OP_DEVW   = 3'h1;
  localparam logic [2:0] OP_ADDR   = 3'h2;
  localparam logic [2:0] OP_RSTART = 3'h3;
  localparam logic [2:0] OP_DEVR   = 3'h4;
  localparam logic [2:0] OP_READ   = 3'h5;
  localparam logic [2:0] OP_STOP   = 3'h6;

  // Bit position of the acknowledge slot, and the four quarters
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [1:0] Q_SETUP   = 2'h0;
  localparam logic [1:0] Q_RISE    = 2'h1;
  localparam logic [1:0] Q_SAMPLE  = 2'h2;
  localparam logic [1:0] Q_FALL    = 2'h3;

  // Loader sequence states
  typedef enum logic [2:0] {
    LD_REQ  = 3'b001,
    LD_WAIT = 3'b010,
    LD_DONE = 3'b100
  } ecl_ld_st_t;

  // Two-wire reader states
  typedef enum logic [1:0] {
    I2_IDLE = 2'b01,
    I2_RUN  = 2'b10
  } ecl_i2_st_t;

endpackage : ecl_pkg

//--- design/ecl_i2c_reader.sv
// Two-wire master that performs one random byte read from the EEPROM.
// Assumes synchronised SCL and SDA levels and open-drain pins outside.
`timescale 1ns/1ps
module ecl_i2c_reader (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Request and answer
  input  wire logic       start,
  input  wire logic [7:0] addr,
  output logic            done,
  output logic            nack,
  output logic [7:0]      rdata,
  // Bus levels, already synchronised
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  // Pin enables, high pulls the line low
  output logic            scl_oe,
  output logic            sda_oe
);

  ecl_pkg::ecl_i2_st_t st_ff, nxt_st;     // Sequencer state
  logic [2:0] op_ff, nxt_op;              // Current operation
  logic [3:0] bit_ff, nxt_bit;            // Bit within a byte
  logic [1:0] q_ff, nxt_q;                // Quarter of a bit
  logic [4:0] cnt_ff, nxt_cnt;            // Cycles within a quarter
  logic [7:0] sh_ff, nxt_sh;              // Shift register
  logic [7:0] addr_ff, nxt_addr;          // Latched word address
  logic       nack_ff, nxt_nack;          // Missing acknowledge seen
  logic       done_ff, nxt_done;          // End of transfer pulse
  logic       scl_ff, nxt_scl;            // Released SCL level
  logic       sda_ff, nxt_sda;            // Released SDA level
  logic       tick;                       // Last cycle of a quarter
  logic       last_bit;                   // Last bit of the operation
  logic       is_byte;                    // Operation moves a byte

  // Byte to shift out when an operation begins
  function automatic logic [7:0] byte_for(input logic [2:0] op,
                                          input logic [7:0] a);
    byte_for = 8'hff;
    if (op == ecl_pkg::OP_DEVW)
      byte_for = {ecl_pkg::EE_DEV_ADDR, 1'b0};
    else if (op == ecl_pkg::OP_ADDR)
      byte_for = a;
    else if (op == ecl_pkg::OP_DEVR)
      byte_for = {ecl_pkg::EE_DEV_ADDR, 1'b1};
  endfunction : byte_for

  assign is_byte  = (op_ff != ecl_pkg::OP_START) &&
                    (op_ff != ecl_pkg::OP_RSTART) &&
                    (op_ff != ecl_pkg::OP_STOP);
  assign last_bit = !is_byte || (bit_ff == ecl_pkg::BIT_ACK);
  assign tick     = (cnt_ff == ecl_pkg::Q_CNT_LAST);

  // Sequencer: quarters, bits and operations of one random read
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_op   = op_ff;
    nxt_bit  = bit_ff;
    nxt_q    = q_ff;
    nxt_cnt  = cnt_ff;
    nxt_sh   = sh_ff;
    nxt_addr = addr_ff;
    nxt_nack = nack_ff;
    nxt_done = 1'b0;
    nxt_scl  = 1'b1;
    nxt_sda  = 1'b1;
    unique case (st_ff)
      ecl_pkg::I2_IDLE:
      begin
        // Bus idles released; a request starts a new read
        if (start)
        begin
          nxt_st   = ecl_pkg::I2_RUN;
          nxt_op   = ecl_pkg::OP_START;
          nxt_bit  = 4'h0;
          nxt_q    = ecl_pkg::Q_SETUP;
          nxt_cnt  = 5'h00;
          nxt_addr = addr;
          nxt_nack = 1'b0;
        end
      end
      ecl_pkg::I2_RUN:
      begin
        // Line levels for the present quarter
        if (op_ff == ecl_pkg::OP_START || op_ff == ecl_pkg::OP_RSTART)
        begin
          nxt_scl = (q_ff == ecl_pkg::Q_RISE) || (q_ff == ecl_pkg::Q_SAMPLE);
          nxt_sda = (q_ff == ecl_pkg::Q_SETUP) || (q_ff == ecl_pkg::Q_RISE);
        end
        else if (op_ff == ecl_pkg::OP_STOP)
        begin
          nxt_scl = (q_ff != ecl_pkg::Q_SETUP);
          nxt_sda = (q_ff == ecl_pkg::Q_SAMPLE) || (q_ff == ecl_pkg::Q_FALL);
        end
        else
        begin
          nxt_scl = (q_ff == ecl_pkg::Q_RISE) || (q_ff == ecl_pkg::Q_SAMPLE);
          // Read data and the closing NACK leave SDA released
          nxt_sda = (op_ff == ecl_pkg::OP_READ) ||
                    (bit_ff == ecl_pkg::BIT_ACK) || sh_ff[7];
        end
        // A slave holding SCL low stretches the high quarter
        if (scl_ff && !scl_in)
          nxt_cnt = cnt_ff;
        else if (!tick)
          nxt_cnt = cnt_ff + 5'h01;
        else
        begin
          nxt_cnt = 5'h00;
          nxt_q   = q_ff + 2'h1;
          // Sample at the end of the high phase, just before SCL falls
          if (is_byte && q_ff == ecl_pkg::Q_SAMPLE)
          begin
            if (bit_ff == ecl_pkg::BIT_ACK)
            begin
              if (op_ff != ecl_pkg::OP_READ && sda_in)
                nxt_nack = 1'b1;
            end
            else if (op_ff == ecl_pkg::OP_READ)
              nxt_sh = {sh_ff[6:0], sda_in};
          end
          // Advance at the end of the low-going quarter
          if (q_ff == ecl_pkg::Q_FALL)
          begin
            if (!last_bit)
            begin
              nxt_bit = bit_ff + 4'h1;
              if (op_ff != ecl_pkg::OP_READ)
                nxt_sh = {sh_ff[6:0], 1'b1};
            end
            else if (op_ff == ecl_pkg::OP_STOP)
            begin
              nxt_st   = ecl_pkg::I2_IDLE;
              nxt_done = 1'b1;
            end
            else
            begin
              nxt_bit = 4'h0;
              // A missing acknowledge ends the read with a stop
              if (nack_ff || op_ff == ecl_pkg::OP_READ)
                nxt_op = ecl_pkg::OP_STOP;
              else
                nxt_op = op_ff + 3'h1;
              if (op_ff != ecl_pkg::OP_READ)
                nxt_sh = byte_for(op_ff + 3'h1, addr_ff);
            end
          end
        end
      end
    endcase
  end

  // Register the sequencer state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff   <= ecl_pkg::I2_IDLE;
      op_ff   <= ecl_pkg::OP_START;
      bit_ff  <= 4'h0;
      q_ff    <= ecl_pkg::Q_SETUP;
      cnt_ff  <= 5'h00;
      sh_ff   <= 8'hff;
      addr_ff <= 8'h00;
      nack_ff <= 1'b0;
      done_ff <= 1'b0;
      scl_ff  <= 1'b1;
      sda_ff  <= 1'b1;
    end
    else
    begin
      st_ff   <= nxt_st;
      op_ff   <= nxt_op;
      bit_ff  <= nxt_bit;
      q_ff    <= nxt_q;
      cnt_ff  <= nxt_cnt;
      sh_ff   <= nxt_sh;
      addr_ff <= nxt_addr;
      nack_ff <= nxt_nack;
      done_ff <= nxt_done;
      scl_ff  <= nxt_scl;
      sda_ff  <= nxt_sda;
    end
  end

  assign done   = done_ff;
  assign nack   = nack_ff;
  assign rdata  = sh_ff;
  assign scl_oe = !scl_ff;
  assign sda_oe = !sda_ff;

endmodule : ecl_i2c_reader

//--- design/ecl_loader_top.sv
// Port configuration loader: six bytes from EEPROM into the registers.
// Assumes an open-drain two-wire bus with pull-ups outside the chip.
`timescale 1ns/1ps
module ecl_loader_top #(
  // Presence word; value is arbitrary
  parameter logic [15:0] PRESENCE_WORD = 16'ha55a
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  // Software register port
  input  wire logic        CFG_WR_STB,
  input  wire logic        CFG_RD_STB,
  input  wire logic [7:0]  CFG_APP_NUM,
  input  wire logic [7:0]  CFG_REG_IDX,
  input  wire logic [7:0]  CFG_WR_DATA,
  output logic      [7:0]  CFG_RD_DATA,
  output logic             CFG_RD_HIT,
  // Configuration fields and load status
  output logic      [23:0] PORT_ONE_CONFIG_FIELD,
  output logic      [23:0] PORT_TWO_CONFIG_FIELD,
  output logic             CFG_LOADING,
  output logic             CFG_VALID,
  output logic             EEPROM_FOUND,
  // Two-wire EEPROM pins
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE
);

  localparam int NPIN = 2;                // SCL and SDA

  logic [7:0] cfg_ff [ecl_pkg::NUM_CFG];  // Configuration bytes
  logic [7:0] nxt_cfg [ecl_pkg::NUM_CFG];
  ecl_pkg::ecl_ld_st_t st_ff, nxt_st;     // Load sequence state
  logic [2:0] step_ff, nxt_step;          // Which byte is read
  logic [7:0] chk_lo_ff, nxt_chk_lo;      // Low presence byte
  logic       found_ff, nxt_found;        // EEPROM accepted
  logic       req_ff, nxt_req;            // Read request pulse
  logic [7:0] rd_data_ff, nxt_rd_data;    // Software read data
  logic       rd_hit_ff, nxt_rd_hit;      // Software read matched
  logic [7:0] ee_addr;                    // Location to read
  logic [2:0] load_slot;                  // Slot of current step
  logic       rd_done;                    // Reader finished
  logic       rd_nack;                    // Reader saw no answer
  logic [7:0] rd_byte;                    // Byte from EEPROM
  logic [3:0] wr_sel;                     // Decoded write target
  logic [3:0] rd_sel;                     // Decoded read target
  logic [NPIN-1:0] pin_raw;               // Raw pin levels
  logic [NPIN-1:0] pin_filt;              // Synchronised levels

  // Decode application number and index into {hit, slot}
  function automatic logic [3:0] slot_of(input logic [7:0] app,
                                         input logic [7:0] idx);
    slot_of = 4'h0;
    for (int i = 0; i < ecl_pkg::NUM_CFG; i++)
    begin
      if (app == ecl_pkg::APP_NUM_CFG && idx == ecl_pkg::CFG_IDX[i])
        slot_of = {1'b1, 3'(i)};
    end
  endfunction : slot_of

  assign pin_raw = {SDA_I, SCL_I};

  // Three-stage synchroniser; a level counts once stages two and
  // three agree, so a single-cycle glitch never reaches the reader
  for (genvar p = 0; p < NPIN; p++)
  begin : g_sync
    logic [2:0] sync_ff, nxt_sync;        // Synchroniser chain
    logic       filt_ff, nxt_filt;        // Accepted level

    always_comb
    begin
      nxt_sync = {sync_ff[1:0], pin_raw[p]};
      nxt_filt = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : filt_ff;
    end

    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
      if (!NRST)
      begin
        sync_ff <= 3'h7;
        filt_ff <= 1'b1;
      end
      else
      begin
        sync_ff <= nxt_sync;
        filt_ff <= nxt_filt;
      end
    end

    assign pin_filt[p] = filt_ff;
  end

  // Location of each step: check word first, then config bytes
  assign load_slot = step_ff - ecl_pkg::STEP_CFG_BASE;
  always_comb
  begin
    if (step_ff == ecl_pkg::STEP_CHK_LO)
      ee_addr = ecl_pkg::EE_LOC_CHK_LO;
    else if (step_ff == ecl_pkg::STEP_CHK_HI)
      ee_addr = ecl_pkg::EE_LOC_CHK_HI;
    else
      ee_addr = ecl_pkg::CFG_EE_LOC[load_slot];
  end

  // Byte reader on the two-wire bus
  ecl_i2c_reader u_reader (
    .clk    (CLK_SYS),
    .rst_n  (NRST),
    .start  (req_ff),
    .addr   (ee_addr),
    .done   (rd_done),
    .nack   (rd_nack),
    .rdata  (rd_byte),
    .scl_in (pin_filt[0]),
    .sda_in (pin_filt[1]),
    .scl_oe (SCL_OE),
    .sda_oe (SDA_OE)
  );

  // Load sequence: check word, then six bytes, then stop for good
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_step   = step_ff;
    nxt_chk_lo = chk_lo_ff;
    nxt_found  = found_ff;
    nxt_req    = 1'b0;
    unique case (st_ff)
      ecl_pkg::LD_REQ:
      begin
        nxt_req = 1'b1;
        nxt_st  = ecl_pkg::LD_WAIT;
      end
      ecl_pkg::LD_WAIT:
      begin
        if (rd_done)
        begin
          if (rd_nack)
            nxt_st = ecl_pkg::LD_DONE;
          else if (step_ff == ecl_pkg::STEP_CHK_LO)
          begin
            nxt_chk_lo = rd_byte;
            nxt_step   = step_ff + 3'h1;
            nxt_st     = ecl_pkg::LD_REQ;
          end
          else if (step_ff == ecl_pkg::STEP_CHK_HI)
          begin
            if ({rd_byte, chk_lo_ff} == PRESENCE_WORD)
            begin
              nxt_step = step_ff + 3'h1;
              nxt_st   = ecl_pkg::LD_REQ;
            end
            else
              nxt_st = ecl_pkg::LD_DONE;
          end
          else if (step_ff == ecl_pkg::STEP_LAST)
          begin
            nxt_found = 1'b1;
            nxt_st    = ecl_pkg::LD_DONE;
          end
          else
          begin
            nxt_step = step_ff + 3'h1;
            nxt_st   = ecl_pkg::LD_REQ;
          end
        end
      end
      ecl_pkg::LD_DONE:
      begin
        // Only a fresh reset starts another load
        nxt_st = ecl_pkg::LD_DONE;
      end
    endcase
  end

  assign wr_sel = slot_of(CFG_APP_NUM, CFG_REG_IDX);
  assign rd_sel = slot_of(CFG_APP_NUM, CFG_REG_IDX);

  // Configuration bytes: loaded from EEPROM, overwritten by software
  always_comb
  begin
    for (int i = 0; i < ecl_pkg::NUM_CFG; i++)
    begin
      nxt_cfg[i] = cfg_ff[i];
      if (st_ff == ecl_pkg::LD_WAIT && rd_done && !rd_nack &&
          step_ff >= ecl_pkg::STEP_CFG_BASE && load_slot == 3'(i))
        nxt_cfg[i] = rd_byte;
      if (CFG_WR_STB && wr_sel[3] && wr_sel[2:0] == 3'(i))
        nxt_cfg[i] = CFG_WR_DATA;
    end
  end

  // Software read: unmapped indexes answer zero with no hit
  always_comb
  begin
    nxt_rd_data = rd_data_ff;
    nxt_rd_hit  = rd_hit_ff;
    if (CFG_RD_STB)
    begin
      nxt_rd_hit  = rd_sel[3];
      nxt_rd_data = rd_sel[3] ? cfg_ff[rd_sel[2:0]] : 8'h00;
    end
  end

  // Register all loader and software-port state
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int i = 0; i < ecl_pkg::NUM_CFG; i++)
        cfg_ff[i] <= ecl_pkg::CFG_RST[i];
      st_ff      <= ecl_pkg::LD_REQ;
      step_ff    <= ecl_pkg::STEP_CHK_LO;
      chk_lo_ff  <= 8'h00;
      found_ff   <= 1'b0;
      req_ff     <= 1'b0;
      rd_data_ff <= 8'h00;
      rd_hit_ff  <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < ecl_pkg::NUM_CFG; i++)
        cfg_ff[i] <= nxt_cfg[i];
      st_ff      <= nxt_st;
      step_ff    <= nxt_step;
      chk_lo_ff  <= nxt_chk_lo;
      found_ff   <= nxt_found;
      req_ff     <= nxt_req;
      rd_data_ff <= nxt_rd_data;
      rd_hit_ff  <= nxt_rd_hit;
    end
  end

  assign PORT_ONE_CONFIG_FIELD = {cfg_ff[2], cfg_ff[1], cfg_ff[0]};
  assign PORT_TWO_CONFIG_FIELD = {cfg_ff[5], cfg_ff[4], cfg_ff[3]};

  // Status and pin outputs; open-drain lines only ever pull low
  assign CFG_LOADING  = (st_ff != ecl_pkg::LD_DONE);
  assign CFG_VALID    = (st_ff == ecl_pkg::LD_DONE);
  assign EEPROM_FOUND = found_ff;
  assign CFG_RD_DATA  = rd_data_ff;
  assign CFG_RD_HIT   = rd_hit_ff;
  assign SCL_O        = 1'b0;
  assign SDA_O        = 1'b0;

endmodule : ecl_loader_top

//--- tb/ecl_loader_monitor.sv
// Port checker for the configuration loader top level.
// Assumes it is bound to ecl_loader_top and sees only its ports.
`timescale 1ns/1ps
module ecl_loader_monitor (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        NRST,
  // Register port
  input wire logic        CFG_WR_STB,
  input wire logic        CFG_RD_STB,
  input wire logic [7:0]  CFG_APP_NUM,
  input wire logic [7:0]  CFG_REG_IDX,
  input wire logic [7:0]  CFG_WR_DATA,
  input wire logic [7:0]  CFG_RD_DATA,
  input wire logic        CFG_RD_HIT,
  // Fields and load status
  input wire logic [23:0] PORT_ONE_CONFIG_FIELD,
  input wire logic [23:0] PORT_TWO_CONFIG_FIELD,
  input wire logic        CFG_LOADING,
  input wire logic        CFG_VALID,
  input wire logic        EEPROM_FOUND
);
  // Strobes aimed at application zero
  wire        wr0 = CFG_WR_STB && CFG_APP_NUM == 8'h00;
  wire        rd0 = CFG_RD_STB && CFG_APP_NUM == 8'h00;
  // Both fields together, for stability checks
  wire [47:0] flds = {PORT_TWO_CONFIG_FIELD, PORT_ONE_CONFIG_FIELD};

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  // Port one middle byte follows a software write
  AST_WR_P1B1: assert property (
    wr0 && CFG_REG_IDX == 8'h05 |=>
      PORT_ONE_CONFIG_FIELD[15:8] == $past(CFG_WR_DATA))
    else $error("port one byte 1 missed a write");
  // Port two top byte sits in bits 23:16
  AST_WR_P2B2: assert property (
    wr0 && CFG_REG_IDX == 8'h1b |=>
      PORT_TWO_CONFIG_FIELD[23:16] == $past(CFG_WR_DATA))
    else $error("port two byte 2 missed a write");
  // Other applications never touch the fields after the load
  AST_WR_IGNORED: assert property (
    CFG_WR_STB && CFG_APP_NUM != 8'h00 && !CFG_LOADING |=> $stable(flds))
    else $error("foreign write changed a field");
  // Without a write or a load the fields keep their value
  AST_HOLD: assert property (
    !$past(CFG_LOADING) && !$past(CFG_WR_STB) |-> $stable(flds))
    else $error("field changed without a write");
  // Mapped read returns the field byte with a hit
  AST_RD_HIT: assert property (
    rd0 && CFG_REG_IDX == 8'h1a |=>
      CFG_RD_HIT && CFG_RD_DATA == $past(PORT_TWO_CONFIG_FIELD[15:8]))
    else $error("mapped read returned a wrong byte");
  // Foreign application reads as zero without a hit
  AST_RD_MISS: assert property (
    CFG_RD_STB && CFG_APP_NUM != 8'h00 |=>
      !CFG_RD_HIT && CFG_RD_DATA == 8'h00)
    else $error("foreign read gave a hit");
  // Built-in values and clear status right after reset
  AST_RST_DFLT: assert property (
    !$past(NRST) |-> PORT_ONE_CONFIG_FIELD == 24'h24_8501 &&
      PORT_TWO_CONFIG_FIELD == 24'h24_8401 && !CFG_VALID && !EEPROM_FOUND)
    else $error("reset values wrong");
  // A finished load is never resumed before the next reset
  AST_VALID_STAY: assert property (
    CFG_VALID |-> !CFG_LOADING ##1 CFG_VALID)
    else $error("valid dropped or load resumed");
  // Found is sticky and comes with a finished load
  AST_FOUND: assert property (
    EEPROM_FOUND |-> ##1 EEPROM_FOUND ##[0:1] CFG_VALID)
    else $error("found without a finished load");

  // Main scenarios reached
  COV_FOUND: cover property ($rose(EEPROM_FOUND));
  COV_NO_EE: cover property ($rose(CFG_VALID) && !EEPROM_FOUND);
  COV_MISS: cover property (CFG_RD_STB && CFG_APP_NUM != 8'h00);
endmodule : ecl_loader_monitor

bind ecl_loader_top ecl_loader_monitor u_mon (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .CFG_WR_STB(CFG_WR_STB),
  .CFG_RD_STB(CFG_RD_STB), .CFG_APP_NUM(CFG_APP_NUM),
  .CFG_REG_IDX(CFG_REG_IDX), .CFG_WR_DATA(CFG_WR_DATA),
  .CFG_RD_DATA(CFG_RD_DATA), .CFG_RD_HIT(CFG_RD_HIT),
  .PORT_ONE_CONFIG_FIELD(PORT_ONE_CONFIG_FIELD),
  .PORT_TWO_CONFIG_FIELD(PORT_TWO_CONFIG_FIELD),
  .CFG_LOADING(CFG_LOADING), .CFG_VALID(CFG_VALID),
  .EEPROM_FOUND(EEPROM_FOUND));

//--- tb/ecl_eeprom_model.sv
// Behavioural two-wire EEPROM answering random byte reads.
// Assumes pull-ups outside; it only ever pulls lines low.
`timescale 1ns/1ps
module ecl_eeprom_model (
  // Bus levels
  input  wire logic scl,
  input  wire logic sda,
  // Behaviour controls
  input  wire logic present,
  input  wire logic slow,
  // Pull-down enables
  output logic      scl_oe,
  output logic      sda_oe
);
  logic [7:0] mem [256]; // Contents, filled by the bench
  logic [7:0] sh;        // Received byte
  logic [7:0] ptr;       // Word pointer
  logic [7:0] txb;       // Byte being sent
  logic       act, tx;   // Frame open, sending data
  logic       ack, adr;  // Byte acknowledged, pointer byte next
  int         bcnt;      // Bit slot, -1 until the first SCL fall
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    act = 1'b0;
  end
  // Start or repeated start: SDA falls while SCL high
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      act = 1'b1;
      tx = 1'b0;
      adr = 1'b0;
      bcnt = -1;
    end
  // Stop ends the frame
  always @(posedge sda)
    if (scl === 1'b1)
      act = 1'b0;
  // Shift in received bits while SCL is high
  always @(posedge scl)
    if (act && !tx && bcnt >= 0 && bcnt < 8)
      sh = {sh[6:0], sda};
  // Slow device: hold SCL low beyond the master's own release
  always @(negedge scl)
    if (act && slow)
    begin
      scl_oe = 1'b1;
      #6000;
      scl_oe = 1'b0;
    end
  // Change SDA only while SCL is low, so no false start or stop
  always @(negedge scl)
    if (act)
    begin
      bcnt++;
      if (bcnt == 8)
      begin
        // Absent device never acknowledges
        ack = present && (adr || sh[7:1] == 7'h50);
        sda_oe = !tx && ack;
      end
      else if (bcnt == 9)
      begin
        bcnt = 0;
        sda_oe = 1'b0;
        if (tx || !ack)
          act = 1'b0;
        else if (adr)
        begin
          ptr = sh;
          adr = 1'b0;
        end
        else if (sh[0])
        begin
          tx = 1'b1;
          txb = mem[ptr];
        end
        else
          adr = 1'b1;
        if (act && tx)
        begin
          sda_oe = !txb[7];
          txb = txb << 1;
        end
      end
      else if (tx)
      begin
        sda_oe = !txb[7];
        txb = txb << 1;
      end
    end
endmodule : ecl_eeprom_model

//--- tb/tb_top.sv
// Self-checking bench: loader against a behavioural EEPROM.
// Assumes pull-ups on both lines, modelled as a wired AND.
`timescale 1ns/1ps
module tb_top;
  // Presence word of the bench image; value is arbitrary
  localparam logic [15:0] PW = 16'h3cc3;
  logic        clk_sys, nrst;    // Clock and reset
  logic        wr_stb, rd_stb;   // Register strobes
  logic [7:0]  app, idx, wdat;   // Register request
  logic [7:0]  rd_data, rnd;     // Read answer, random state
  logic        rd_hit, loading, valid, found;
  logic [23:0] f1, f2;           // Port fields
  logic        scl_oe, sda_oe, ee_scl_oe, ee_sda_oe;
  logic        present, slow;    // Model behaviour
  logic [7:0]  regs [6];         // Expected register contents
  logic [8:0]  exp_q [$];        // Expected {hit, data} per read
  int          n_mismatch, comparisons;
  int          cyc = 0;          // Cycle count for the hang guard
  // Open-drain lines with pull-ups
  wire         scl = ~(scl_oe | ee_scl_oe);
  wire         sda = ~(sda_oe | ee_sda_oe);

  ecl_loader_top #(.PRESENCE_WORD(PW)) dut (
    .CLK_SYS(clk_sys), .NRST(nrst),
    .CFG_WR_STB(wr_stb), .CFG_RD_STB(rd_stb), .CFG_APP_NUM(app),
    .CFG_REG_IDX(idx), .CFG_WR_DATA(wdat), .CFG_RD_DATA(rd_data),
    .CFG_RD_HIT(rd_hit), .PORT_ONE_CONFIG_FIELD(f1),
    .PORT_TWO_CONFIG_FIELD(f2), .CFG_LOADING(loading),
    .CFG_VALID(valid), .EEPROM_FOUND(found), .SCL_I(scl), .SCL_O(),
    .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe));
  ecl_eeprom_model u_ee (.scl(scl), .sda(sda), .present(present),
    .slow(slow), .scl_oe(ee_scl_oe), .sda_oe(ee_sda_oe));

  // 10 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Hang guard: the three loads need about half of this
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  // Random source for data bytes
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Read answers: {hit, data} against the oldest note
  task automatic chk_rd(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_rd
  // One access held over one rising edge; strobes left up for chaining
  task automatic acc(input logic w, input logic [7:0] a, i, d,
                     input logic [8:0] e);
    wr_stb = w;
    rd_stb = !w;
    app = a;
    idx = i;
    wdat = d;
    if (!w)
      exp_q.push_back(e);
    @(negedge clk_sys);
  endtask : acc
  // Back-to-back reads of all bytes and two misses, then the fields
  task automatic chk_all;
    for (int k = 0; k < ecl_pkg::NUM_CFG; k++)
      acc(1'b0, 8'h00, ecl_pkg::CFG_IDX[k], 8'h00, {1'b1, regs[k]});
    acc(1'b0, 8'h01, 8'h04, 8'h00, 9'h000);
    acc(1'b0, 8'h00, 8'h07, 8'h00, 9'h000);
    rd_stb = 1'b0;
    // Let an edge pass so the next access never re-drives the strobe
    @(negedge clk_sys);
    chk(f1, {regs[2], regs[1], regs[0]});
    chk(f2, {regs[5], regs[4], regs[3]});
  endtask : chk_all
  // Reset for three cycles, then wait for the load to finish
  task automatic load(input logic want);
    nrst = 1'b0;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    while (valid !== 1'b1) @(negedge clk_sys);
    chk(24'(found), 24'(want));
  endtask : load
  task automatic end_of_test;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Each read answer against the oldest note
  always @(posedge clk_sys)
    if (rd_stb === 1'b1)
    begin
      @(negedge clk_sys);
      chk_rd({rd_hit, rd_data}, exp_q.pop_front());
    end

  initial
  begin
    // Reset and presence are first set below, at the same instant
    {wr_stb, rd_stb, slow} = 3'h0;
    app = 8'h00;
    idx = 8'h00;
    wdat = 8'h00;
    rnd = 8'h5e;
    // image: UTF-16 text from 24, language id low first
    for (int i = 0; i < 256; i++)
      u_ee.mem[i] = (i >= 24 && i[0]) ? 8'h00 : 8'h41;
    u_ee.mem[22] = 8'h09;
    u_ee.mem[23] = 8'h04;
    u_ee.mem[0] = PW[7:0];
    u_ee.mem[1] = PW[15:8];
    for (int k = 0; k < ecl_pkg::NUM_CFG; k++)
    begin
      rnd = lfsr(rnd);
      regs[k] = rnd;
      u_ee.mem[ecl_pkg::CFG_EE_LOC[k]] = rnd;
    end
    present = 1'b1;
    load(1'b1);
    chk_all();
    // Random software writes, then an ignored foreign one and an ignored unmapped one
    for (int k = 0; k < ecl_pkg::NUM_CFG; k++)
    begin
      rnd = lfsr(rnd);
      regs[k] = rnd;
      acc(1'b1, 8'h00, ecl_pkg::CFG_IDX[k], rnd, 9'h000);
    end
    acc(1'b1, 8'h02, 8'h05, 8'hff, 9'h000);
    acc(1'b1, 8'h00, 8'h1c, 8'hff, 9'h000);
    chk_all();
    // Wrong presence word from a slow device: defaults stay
    u_ee.mem[1] = ~PW[15:8];
    slow = 1'b1;
    for (int k = 0; k < ecl_pkg::NUM_CFG; k++)
      regs[k] = ecl_pkg::CFG_RST[k];
    load(1'b0);
    chk_all();
    // No device answers at all
    present = 1'b0;
    slow = 1'b0;
    load(1'b0);
    chk_all();
    end_of_test();
  end
endmodule : tb_top
